// >>> inc/mhp_defines.vh
// Purpose: Shared constants of the multiplexed host bus slave port
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef MHP_DEFINES_VH
`define MHP_DEFINES_VH

// ----------------------------------------
// Core clock
// ----------------------------------------
`define MHP_CORE_CLK_HZ 40000000
`define MHP_SYNC_STAGES 2

// ----------------------------------------
// Access classes
// ----------------------------------------
`define MHP_ACC_W 3
`define MHP_ACC_NONE 3'h0
`define MHP_ACC_WR16 3'h1
`define MHP_ACC_WR_ODD 3'h2
`define MHP_ACC_WR_EVEN 3'h3
`define MHP_ACC_RD16 3'h4
`define MHP_ACC_UNSUP 3'h5

// ----------------------------------------
// Byte enables: bit 1 even byte, bit 0 odd byte
// ----------------------------------------
`define MHP_BE_NONE 2'h0
`define MHP_BE_WORD 2'h3
`define MHP_BE_EVEN 2'h2
`define MHP_BE_ODD 2'h1

// ----------------------------------------
// Decode patterns and field positions
// ----------------------------------------
`define MHP_PAGE_ZERO 6'h00
`define MHP_IFSEL_HOSTBUS 2'h2
`define MHP_ADDR_SEL_HI 15
`define MHP_ADDR_SEL_LO 13
`define MHP_BYTE_ZERO 8'h00
`define MHP_WORD_ZERO 16'h0000

// ----------------------------------------
// Link phase states
// ----------------------------------------
`define MHP_ST_LOW 1'h0
`define MHP_ST_HIGH 1'h1

`endif

// >>> rtl/mhp_sync.v
// Purpose: Two flip-flop synchroniser for a bundle of pin levels
// Assumes: Each bit is a slowly changing level relative to SYS_CLK
// Notes: Bits are not coherent with each other during a change
`timescale 1ns/10ps
`include "mhp_defines.vh"

module mhp_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_r;

  // First stage read only by the second stage
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // mhp_sync

// >>> rtl/mhp_host_port.v
// Purpose: Slave end of a multiplexed expanded host bus, paced by the host bus clock
// Assumes: SYS_CLK is the 40 MHz core clock; host inserts bus stretch cycles
// Notes: Address taken in the low phase, data moved in the high phase
`timescale 1ns/10ps
`include "mhp_defines.vh"

// Contract
// - Port runs only from 40 MHz core clock
// - Aligned word reads, byte/word writes, no byte reads
// - Classify from select, strobe, A0, direction
// - Direction low writes, high reads
// - Word write: upper lane even, lower odd
// - Odd byte write from lower lane
// - Even byte write from lower lane
// - Word read: even upper, odd lower lane
// - Other selected combinations do no transfer
// - Select needs extended page address zero
// - Select needs top address bits match straps
// - Enable only with select straps high/low
module mhp_host_port #(
  parameter CORE_CLK_HZ = `MHP_CORE_CLK_HZ
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire NRST,
  // Core clock source status, same domain
  input wire CORE_OSC_SELECTED,
  // Host bus pins
  input wire HOST_BUS_CLOCK,
  input wire LOW_BYTE_STROBE,
  input wire TRANSFER_DIRECTION_N,
  input wire [5:0] EXTENDED_PAGE_ADDRESS,
  input wire [7:0] UPPER_DATA_LANE_IN,
  input wire [7:0] LOWER_DATA_LANE_IN,
  output reg [7:0] UPPER_DATA_LANE_OUT,
  output reg UPPER_DATA_LANE_OE,
  output reg [7:0] LOWER_DATA_LANE_OUT,
  output reg LOWER_DATA_LANE_OE,
  // Straps
  input wire [2:0] ADDRESS_SELECT_STRAPS,
  input wire INTERFACE_SELECT_HI,
  input wire INTERFACE_SELECT_LO,
  // Core access side
  output reg CORE_WR,
  output reg CORE_RD,
  output reg [15:0] CORE_ADDR,
  output reg [15:0] CORE_WDATA,
  output reg [1:0] CORE_BE,
  input wire [15:0] CORE_RDATA,
  output reg ACCESS_ERROR,
  output reg PORT_ENABLED
);

  // ----------------------------------------
  // Access classification
  // ----------------------------------------
  function [`MHP_ACC_W-1:0] classify;
    input cs;
    input dir_n;
    input low_byte_strobe;
    input a0;
    begin
      if (!cs)
        classify = `MHP_ACC_NONE;
      else if (!dir_n) begin
        case ({low_byte_strobe, a0})
          2'h0: classify = `MHP_ACC_WR16;
          2'h1: classify = `MHP_ACC_WR_ODD;
          2'h2: classify = `MHP_ACC_WR_EVEN;
          default: classify = `MHP_ACC_UNSUP;
        endcase
      end else if (!low_byte_strobe && !a0)
        classify = `MHP_ACC_RD16;
      else
        classify = `MHP_ACC_UNSUP;
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  // All pins share the same delay, but bits changing together may resolve a cycle apart
  wire [29:0] pins_s;
  mhp_sync #(
    .W(30)
  ) u_sync (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .d({HOST_BUS_CLOCK, LOW_BYTE_STROBE, TRANSFER_DIRECTION_N, EXTENDED_PAGE_ADDRESS,
        UPPER_DATA_LANE_IN, LOWER_DATA_LANE_IN, ADDRESS_SELECT_STRAPS,
        INTERFACE_SELECT_HI, INTERFACE_SELECT_LO}),
    .q(pins_s)
  );

  wire eclk_s = pins_s[29];
  wire low_byte_strobe_s = pins_s[28];
  wire dir_n_s = pins_s[27];
  wire [5:0] page_s = pins_s[26:21];
  wire [7:0] upper_s = pins_s[20:13];
  wire [7:0] lower_s = pins_s[12:5];
  wire [2:0] straps_s = pins_s[4:2];
  wire [1:0] ifsel_s = pins_s[1:0];

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  reg straps_armed_r;
  reg ifsel_ok_r;
  reg [2:0] straps_r;

  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      straps_armed_r <= 1'b0;
      ifsel_ok_r <= 1'b0;
      straps_r <= 3'h0;
    end else if (!straps_armed_r) begin
      // Wait one edge; the first capture after it still sees the synchroniser reset levels
      straps_armed_r <= 1'b1;
    end else begin
      ifsel_ok_r <= (ifsel_s == `MHP_IFSEL_HOSTBUS);
      straps_r <= straps_s;
    end
  end

  wire clk_ok = CORE_OSC_SELECTED && (CORE_CLK_HZ == `MHP_CORE_CLK_HZ);
  wire enable_nxt = clk_ok && ifsel_ok_r;

  // ----------------------------------------
  // Bus clock phase tracking
  // ----------------------------------------
  reg eclk_d_r;
  reg phase_r;
  reg [15:0] addr_r;
  reg [15:0] wlanes_r;
  reg [`MHP_ACC_W-1:0] acc_r;
  reg rd_pend_r;

  wire eclk_rise = eclk_s && !eclk_d_r;
  wire eclk_fall = !eclk_s && eclk_d_r;

  wire page_hit = (page_s == `MHP_PAGE_ZERO);
  // top bits match straps in order
  wire sel_hit = (addr_r[`MHP_ADDR_SEL_HI:`MHP_ADDR_SEL_LO] == straps_r);
  wire cs = PORT_ENABLED && page_hit && sel_hit;
  wire [`MHP_ACC_W-1:0] acc_now = classify(cs, dir_n_s, low_byte_strobe_s, addr_r[0]);

  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      eclk_d_r <= 1'b0;
      phase_r <= `MHP_ST_LOW;
      addr_r <= `MHP_WORD_ZERO;
      wlanes_r <= `MHP_WORD_ZERO;
      acc_r <= `MHP_ACC_NONE;
      rd_pend_r <= 1'b0;
      PORT_ENABLED <= 1'b0;
      CORE_WR <= 1'b0;
      CORE_RD <= 1'b0;
      CORE_ADDR <= `MHP_WORD_ZERO;
      CORE_WDATA <= `MHP_WORD_ZERO;
      CORE_BE <= `MHP_BE_NONE;
      ACCESS_ERROR <= 1'b0;
      UPPER_DATA_LANE_OUT <= `MHP_BYTE_ZERO;
      LOWER_DATA_LANE_OUT <= `MHP_BYTE_ZERO;
      UPPER_DATA_LANE_OE <= 1'b0;
      LOWER_DATA_LANE_OE <= 1'b0;
    end else begin
      eclk_d_r <= eclk_s;
      PORT_ENABLED <= enable_nxt;
      CORE_WR <= 1'b0;
      CORE_RD <= 1'b0;
      ACCESS_ERROR <= 1'b0;
      rd_pend_r <= 1'b0;
      case (phase_r)
        `MHP_ST_LOW: begin
          if (!eclk_s)
            addr_r <= {upper_s, lower_s};
          // Held address is the last low-phase sample, so short hold is safe
          if (eclk_rise) begin
            phase_r <= `MHP_ST_HIGH;
            acc_r <= acc_now;
            CORE_ADDR <= addr_r;
            if (acc_now == `MHP_ACC_RD16) begin
              CORE_RD <= 1'b1;
              CORE_BE <= `MHP_BE_WORD;
              rd_pend_r <= 1'b1;
            end
            if (acc_now == `MHP_ACC_UNSUP)
              ACCESS_ERROR <= 1'b1;
          end
        end
        `MHP_ST_HIGH: begin
          if (eclk_s)
            wlanes_r <= {upper_s, lower_s};
          if (rd_pend_r) begin
            UPPER_DATA_LANE_OUT <= CORE_RDATA[15:8];
            LOWER_DATA_LANE_OUT <= CORE_RDATA[7:0];
            UPPER_DATA_LANE_OE <= 1'b1;
            LOWER_DATA_LANE_OE <= 1'b1;
          end
          if (eclk_fall) begin
            phase_r <= `MHP_ST_LOW;
            UPPER_DATA_LANE_OE <= 1'b0;
            LOWER_DATA_LANE_OE <= 1'b0;
            acc_r <= `MHP_ACC_NONE;
            case (acc_r)
              `MHP_ACC_WR16: begin
                CORE_WR <= 1'b1;
                CORE_WDATA <= wlanes_r;
                CORE_BE <= `MHP_BE_WORD;
              end
              `MHP_ACC_WR_ODD: begin
                CORE_WR <= 1'b1;
                CORE_WDATA <= {`MHP_BYTE_ZERO, wlanes_r[7:0]};
                CORE_BE <= `MHP_BE_ODD;
              end
              `MHP_ACC_WR_EVEN: begin
                CORE_WR <= 1'b1;
                CORE_WDATA <= {wlanes_r[7:0], `MHP_BYTE_ZERO};
                CORE_BE <= `MHP_BE_EVEN;
              end
              default: begin
                CORE_WR <= 1'b0;
              end
            endcase
          end
        end
        default: begin
          phase_r <= `MHP_ST_LOW;
        end
      endcase
    end
  end

endmodule // mhp_host_port

// >>> tb/mhp_monitor.sv
// Purpose: Checker on the host port outputs
// Assumes: Bound onto mhp_host_port from the bench
// Notes: Watches device driven signals only
`timescale 1ns/10ps
module mhp_monitor (
  // Watched ports
  input wire SYS_CLK,
  input wire NRST,
  input wire UPPER_DATA_LANE_OE,
  input wire CORE_WR,
  input wire CORE_RD,
  input wire [15:0] CORE_ADDR,
  input wire [1:0] CORE_BE,
  input wire ACCESS_ERROR,
  input wire PORT_ENABLED
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  a_wr_pulse: assert property (CORE_WR |=> !CORE_WR) else $error("long write");
  a_rd_pulse: assert property (CORE_RD |=> !CORE_RD) else $error("long read");
  a_rd_word:
    assert property (CORE_RD |-> CORE_BE == 2'h3 && !CORE_ADDR[0]) else $error("read form");
  a_rd_drive: assert property (CORE_RD |=> UPPER_DATA_LANE_OE) else $error("no drive");
  a_wr_quiet:
    assert property (CORE_WR |-> !UPPER_DATA_LANE_OE && !CORE_RD) else $error("write drive");
  a_be_addr:
    assert property (CORE_WR |-> CORE_BE != 2'h0 && (CORE_BE == 2'h1) == CORE_ADDR[0])
      else $error("byte lanes");
  a_err_alone:
    assert property (ACCESS_ERROR |-> !CORE_RD ##1 !ACCESS_ERROR && !CORE_RD) else $error("error");
  a_off_quiet:
    assert property (!PORT_ENABLED |-> !CORE_WR && !CORE_RD && !ACCESS_ERROR) else $error("off");
endmodule // mhp_monitor

// >>> tb/mhp_host_model.sv
// Purpose: Host bus master model
// Assumes: Pins move 1 ns after a core clock edge
// Notes: Released lanes show the inverse of the last value
`timescale 1ns/10ps
module mhp_host_model (
  // Pins
  input wire ck,
  output reg ec = 1'b0,
  output reg ls = 1'b1,
  output reg dn = 1'b1,
  output reg [5:0] pg = 6'h00,
  output wire [7:0] up,
  output wire [7:0] lp,
  // Device drive
  input wire [7:0] uo,
  input wire uoe,
  input wire [7:0] lo,
  input wire loe
);
  localparam STRETCH = 1;
  reg [15:0] drv = 16'h0000;
  assign up = uoe ? uo : drv[15:8];
  assign lp = loe ? lo : drv[7:0];
  task xfer(input d, input s, input [15:0] a, input [5:0] p, input [15:0] w, output [15:0] r);
    begin
      @(posedge ck) #1 {dn, ls, pg, drv} = {d, s, p, a};
      repeat (4) @(posedge ck);
      #1 {ec, drv} = {1'b1, d ? ~a : w};
      repeat (4 * (1 + STRETCH)) @(posedge ck);
      r = {up, lp};
      #1 {ec, drv} = {1'b0, ~drv};
      repeat (3) @(posedge ck);
    end
  endtask
endmodule // mhp_host_model

// >>> tb/tb.sv
// Purpose: Self-checking bench for the host bus slave port
// Assumes: Straps select 3'h4 on the top address bits
// Notes: Expected results follow the access table
`timescale 1ns/10ps
module tb;
  reg ck = 1'b0, rn = 1'b0, isl = 1'b0, osl = 1'b1;
  reg [15:0] rdw = 16'h0000, a, d, got, ed;
  reg [31:0] x = 32'h13B0;
  reg [1:0] eb;
  integer err_count = 0, cmp_count = 0, nw = 0, nr = 0, ne = 0, k, i;
  wire ec, ls, dn, uoe, loe, wr, rd, er, en;
  wire [5:0] pg;
  wire [7:0] up, lp, uo, lo;
  wire [15:0] ca, cw;
  wire [1:0] be;
  initial forever #12.5 ck = ~ck;
  mhp_host_model h (.ck, .ec, .ls, .dn, .pg, .up, .lp, .uo, .uoe, .lo, .loe);
  mhp_host_port dut (.SYS_CLK(ck), .NRST(rn), .CORE_OSC_SELECTED(osl), .HOST_BUS_CLOCK(ec),
    .LOW_BYTE_STROBE(ls), .TRANSFER_DIRECTION_N(dn), .EXTENDED_PAGE_ADDRESS(pg),
    .UPPER_DATA_LANE_IN(up), .LOWER_DATA_LANE_IN(lp), .UPPER_DATA_LANE_OUT(uo),
    .UPPER_DATA_LANE_OE(uoe), .LOWER_DATA_LANE_OUT(lo), .LOWER_DATA_LANE_OE(loe),
    .ADDRESS_SELECT_STRAPS(3'h4), .INTERFACE_SELECT_HI(1'b1), .INTERFACE_SELECT_LO(isl),
    .CORE_WR(wr), .CORE_RD(rd), .CORE_ADDR(ca), .CORE_WDATA(cw), .CORE_BE(be),
    .CORE_RDATA(rdw), .ACCESS_ERROR(er), .PORT_ENABLED(en));
  always @(posedge ck) begin
    nw <= nw + wr;
    nr <= nr + rd;
    ne <= ne + er;
  end
  function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input [33:0] g, input [33:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // Pulses counted over the whole bus cycle, then lanes compared
  task run(input [2:0] c, input [5:0] p, input [2:0] hi);
    begin
      #1 x = xs(x);
      {a, d, rdw, nw, nr, ne} = {hi, x[12:1], c[0], x[31:16], ~x[31:16], 96'h0};
      h.xfer(c[2], c[1], a, p, d, got);
      repeat (4) @(posedge ck);
      k = (isl || !osl || p != 6'h00 || hi != 3'h4) ? 0 : (c < 3'h3) ? 1 : (c == 3'h4) ? 2 : 3;
      eb = c[1:0] == 2'h0 ? 2'h3 : {~c[0], c[0]};
      ed = (eb == 2'h3 ? d : {2{d[7:0]}}) & {{8{eb[1]}}, {8{eb[0]}}};
      chk(nw * 100 + nr * 10 + ne, k == 1 ? 100 : k == 2 ? 10 : k == 3);
      if (k == 1) chk({be, ca, cw & {{8{eb[1]}}, {8{eb[0]}}}}, {eb, a, ed});
      if (k == 2) chk({be, ca, got}, {2'h3, a, rdw});
      $display("access %h page %h done", c, p);
    end
  endtask
  task rst(input v);
    begin
      #1 rn = 1'b0;
      isl = v;
      repeat (6) @(posedge ck);
      #1 rn = 1'b1;
      repeat (8) @(posedge ck);
    end
  endtask
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    rst(1'b0);
    chk(en, 1);
    for (i = 0; i < 16; i = i + 1) run(i[2:0], 6'h00, 3'h4);
    run(3'h0, 6'h01, 3'h4);
    run(3'h4, 6'h20, 3'h4);
    run(3'h0, 6'h00, 3'h5);
    #1 osl = 1'b0;
    repeat (2) @(posedge ck);
    chk(en, 0);
    run(3'h0, 6'h00, 3'h4);
    #1 osl = 1'b1;
    rst(1'b1);
    chk(en, 0);
    run(3'h0, 6'h00, 3'h4);
    end_of_test;
  end
  // Whole run needs about 11 us
  initial #100000 begin
    err_count = err_count + 1;
    end_of_test;
  end
endmodule // tb
bind mhp_host_port mhp_monitor mon (.SYS_CLK, .NRST, .UPPER_DATA_LANE_OE, .CORE_WR, .CORE_RD,
  .CORE_ADDR, .CORE_BE, .ACCESS_ERROR, .PORT_ENABLED);
